// ===== shared/arfmt_pkg.sv
// Package: register map, field layout and timing constants for the converter result block
package arfmt_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL_TWO = 4'h0; // Conversion control two
    localparam logic [3:0] OFS_RES_HIGH = 4'h4; // Result high byte
    localparam logic [3:0] OFS_RES_LOW = 4'h8; // Result low byte
    localparam logic [3:0] OFS_START = 4'hC; // Start command and busy status

    // ------------------------------------------------------------
    // Field positions in conversion control two and in the start register
    // ------------------------------------------------------------
    localparam int POS_JUSTIFY = 7; // Result justification select
    localparam int POS_ACQ_LSB = 3; // Acquisition time select, 3 bits
    localparam int POS_CLK_LSB = 0; // Conversion clock select, 3 bits
    localparam logic [7:0] CTRL_WMASK = 8'hBF; // Bit 6 is unimplemented
    localparam logic [7:0] CTRL_RESET = 8'h00; // Control value after reset
    localparam int POS_GO = 0; // Start bit, reads back as busy
    localparam int POS_DONE = 1; // Done flag, writing one clears it

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100; // System clock period
    localparam int INSTR_CYCLE_CLKS = 4; // One instruction cycle in system clocks
    localparam int RC_DIV_DEFAULT = 8; // Dedicated RC clock modelled as a divider
    localparam int CONV_BITS = 10; // Bit periods spent on the conversion itself
    localparam int DISCHARGE_PERIODS = 1; // Bit periods spent discharging the hold cap
    // Clocks per bit period minus one, by clock select code; RC codes take RC_DIV instead
    localparam logic [7:0][7:0] CLK_DIV_MAX = {8'h00, 8'h3F, 8'h0F, 8'h03,
                                               8'h00, 8'h1F, 8'h07, 8'h01};
    // Acquisition length in bit periods, by acquisition select code
    localparam logic [7:0][4:0] ACQ_PERIODS = {5'h14, 5'h10, 5'h0C, 5'h08,
                                               5'h06, 5'h04, 5'h02, 5'h00};

    // Result fed into the block by the analog core
    typedef struct packed {
        logic valid; // One-cycle pulse when the SAR finishes
        logic [9:0] value; // Raw 10-bit result
    } arfmt_result_t;

    // Converter control presented to the analog core
    typedef struct packed {
        logic sample; // Sampling switch closed
        logic convert; // SAR running
        logic discharge; // Hold capacitor being discharged
        logic bit_tick; // One pulse per conversion bit period
    } arfmt_analog_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RCWAIT = 3'b001,
        ST_ACQ = 3'b010,
        ST_CONV = 3'b011,
        ST_DISCH = 3'b100
    } arfmt_state_t;

endpackage

// ===== verilog/arfmt_core.sv
// Converter result formatting, acquisition timing and clock select behind an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Function
// - Left justified: high register holds result[9:2]
// - Left justified: low bits 7:6 hold result[1:0]
// - Right justified: high bits 1:0 hold result[9:8]
// - Right justified: low register holds result[7:0]
// - Discharge hold capacitor after every conversion
module arfmt_core #(
    parameter int RC_DIV = arfmt_pkg::RC_DIV_DEFAULT // System clocks per RC period
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog core
    input wire arfmt_pkg::arfmt_result_t result_in,
    output arfmt_pkg::arfmt_analog_t analog_ctl
);
    import arfmt_pkg::*;

    // Prescaler is 8 bits and a bit period needs at least two clocks
    if (RC_DIV < 2 || RC_DIV > 255) begin : g_bad_rc_div
        $error("RC_DIV out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl, next_ctrl; // Conversion control two
    logic [7:0] res_high, next_res_high; // Result high byte
    logic [7:0] res_low, next_res_low; // Result low byte
    logic done, next_done; // Conversion finished flag
    arfmt_state_t state, next_state; // Sequencer state
    logic [7:0] div_cnt, next_div_cnt; // Bit period prescaler
    logic [4:0] per_cnt, next_per_cnt; // Bit periods left in phase
    logic tick; // End of one bit period
    logic [7:0] div_max; // Clocks per bit period minus one
    logic [4:0] acq_periods; // Acquisition length in bit periods
    // Bus handshake state
    logic aw_held, next_aw_held; // Write address captured
    logic w_held, next_w_held; // Write data captured
    logic [3:0] aw_addr, next_aw_addr; // Captured write address
    logic [31:0] w_data, next_w_data; // Captured write data
    logic [3:0] w_strb, next_w_strb; // Captured strobes
    logic bvalid, next_bvalid; // Write response pending
    logic [1:0] bresp, next_bresp; // Write response code
    logic rvalid, next_rvalid; // Read data pending
    logic [31:0] rdata, next_rdata; // Read data
    logic [1:0] rresp, next_rresp; // Read response code
    logic do_write; // Both halves of a write present
    logic go_write; // Software sets the start bit

    // ------------------------------------------------------------
    // Bit period and acquisition decode
    // ------------------------------------------------------------
    // Clock select decode; slow clocks kept as divider ratios, codes 011/111 are the RC clock
    assign div_max = (ctrl[POS_CLK_LSB +: 2] == 2'b11) ? 8'(RC_DIV - 1)
                                                        : CLK_DIV_MAX[ctrl[POS_CLK_LSB +: 3]];

    // Acquisition field decode
    assign acq_periods = ACQ_PERIODS[ctrl[POS_ACQ_LSB +: 3]];

    assign tick = (div_cnt == div_max);
    assign do_write = aw_held && w_held && !bvalid;
    assign go_write = do_write && (aw_addr == OFS_START) && w_strb[0] && w_data[POS_GO];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Runs acquisition, conversion and discharge in bit periods
    always_comb begin
        next_state = state;
        next_per_cnt = per_cnt;
        // Prescaler restarts with each phase so periods are whole
        next_div_cnt = (state == ST_IDLE || tick) ? 8'h00 : div_cnt + 8'h01;
        unique case (state)
            ST_IDLE: begin
                if (go_write) begin
                    if (ctrl[POS_CLK_LSB +: 3] == 3'b011 || ctrl[POS_CLK_LSB +: 3] == 3'b111) begin
                        next_state = ST_RCWAIT;
                        next_per_cnt = 5'(INSTR_CYCLE_CLKS - 1);
                    end else if (acq_periods == 5'h00) begin
                        next_state = ST_CONV;
                        next_per_cnt = 5'(CONV_BITS - 1);
                    end else begin
                        next_state = ST_ACQ;
                        next_per_cnt = acq_periods - 5'h01;
                    end
                end
            end
            ST_RCWAIT: begin
                // One instruction cycle of system clocks before anything starts
                next_div_cnt = 8'h00;
                if (per_cnt == 5'h00) begin
                    next_state = (acq_periods == 5'h00) ? ST_CONV : ST_ACQ;
                    next_per_cnt = (acq_periods == 5'h00) ? 5'(CONV_BITS - 1) : acq_periods - 1'b1;
                end else begin
                    next_per_cnt = per_cnt - 5'h01;
                end
            end
            ST_ACQ: begin
                if (tick) begin
                    if (per_cnt == 5'h00) begin
                        next_state = ST_CONV;
                        next_per_cnt = 5'(CONV_BITS - 1);
                    end else begin
                        next_per_cnt = per_cnt - 5'h01;
                    end
                end
            end
            ST_CONV: begin
                if (tick) begin
                    if (per_cnt == 5'h00) begin
                        next_state = ST_DISCH;
                        next_per_cnt = 5'(DISCHARGE_PERIODS - 1);
                    end else begin
                        next_per_cnt = per_cnt - 5'h01;
                    end
                end
            end
            ST_DISCH: begin
                if (tick && per_cnt == 5'h00) begin
                    next_state = ST_IDLE;
                end else if (tick) begin
                    next_per_cnt = per_cnt - 5'h01;
                end
            end
            default: next_state = ST_IDLE; // Illegal codes recover to idle
        endcase
    end

    // Analog controls straight from the sequencer
    always_comb begin
        analog_ctl.sample = (state == ST_ACQ) || (state == ST_RCWAIT) || (state == ST_IDLE);
        analog_ctl.convert = (state == ST_CONV);
        analog_ctl.discharge = (state == ST_DISCH);
        analog_ctl.bit_tick = tick && (state == ST_CONV);
    end

    // ------------------------------------------------------------
    // Register file and result formatting
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_res_high = res_high;
        next_res_low = res_low;
        next_done = done;
        if (do_write && w_strb[0]) begin
            unique case (aw_addr)
                OFS_CTRL_TWO: next_ctrl = w_data[7:0] & CTRL_WMASK;
                OFS_RES_HIGH: next_res_high = w_data[7:0];
                OFS_RES_LOW: next_res_low = w_data[7:0];
                OFS_START: next_done = w_data[POS_DONE] ? 1'b0 : done;
                default: next_ctrl = ctrl;
            endcase
        end
        // Hardware result wins over a same-cycle software write
        if (result_in.valid && state == ST_CONV) begin
            next_done = 1'b1;
            if (ctrl[POS_JUSTIFY]) begin
                next_res_high = {6'h00, result_in.value[9:8]};
                next_res_low = result_in.value[7:0];
            end else begin
                next_res_high = result_in.value[9:2];
                next_res_low = {result_in.value[1:0], 6'h00};
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data taken in either order; response after both
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr[1:0] == 2'b00 && aw_addr <= OFS_START) ? 2'b00 : 2'b10;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = 2'b00;
            unique case (s_axi_araddr)
                OFS_CTRL_TWO: next_rdata = {24'h00_0000, ctrl};
                OFS_RES_HIGH: next_rdata = {24'h00_0000, res_high};
                OFS_RES_LOW: next_rdata = {24'h00_0000, res_low};
                OFS_START: next_rdata = {30'h0000_0000, done, state != ST_IDLE};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = 2'b10; // Unmapped address
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // Registers only; all next values come from above
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            res_high <= 8'h00;
            res_low <= 8'h00;
            done <= 1'b0;
            state <= ST_IDLE;
            div_cnt <= 8'h00;
            per_cnt <= 5'h00;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end else begin
            ctrl <= next_ctrl;
            res_high <= next_res_high;
            res_low <= next_res_low;
            done <= next_done;
            state <= next_state;
            div_cnt <= next_div_cnt;
            per_cnt <= next_per_cnt;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

endmodule // arfmt_core

// ===== tb/arfmt_checker.sv
// Checker: bus handshake and converter sequencing properties
`timescale 1ns/100ps
module arfmt_checker #(
    parameter int RC_DIV = 8 // System clocks per RC period
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Analog control
    input wire arfmt_pkg::arfmt_analog_t analog_ctl
);
    import arfmt_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Longest bit period any clock code can give
    localparam int MAXP = (RC_DIV > 64) ? RC_DIV : 64;
    int disch_cnt; // Cycles spent discharging so far
    int next_disch_cnt;
    // Count discharge cycles; a stuck discharge would starve the next sample
    always_comb begin
        next_disch_cnt = analog_ctl.discharge ? disch_cnt + 1 : 0;
    end
    always_ff @(posedge aclk) begin
        disch_cnt <= aresetn ? next_disch_cnt : 0;
    end
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence conv_end;
        $fell(analog_ctl.convert);
    endsequence
    sequence conv_start;
        $rose(analog_ctl.convert);
    endsequence
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before it was taken");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed while held");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_ANSWER: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_DISCH_AFTER: assert property (conv_end |-> analog_ctl.discharge)
        else $error("no discharge after conversion");
    AST_DISCH_LEN: assert property (disch_cnt <= MAXP)
        else $error("discharge lasts too long");
    AST_TICK_IN_CONV: assert property (analog_ctl.bit_tick |-> analog_ctl.convert ##1
        !analog_ctl.bit_tick) else $error("bit tick outside conversion or too long");
    AST_CONV_AFTER_SAMPLE: assert property (conv_start |-> $past(analog_ctl.sample))
        else $error("conversion began without a sampling phase");
    AST_ACQ_EXCL: assert property (!(analog_ctl.sample &&
        (analog_ctl.convert || analog_ctl.discharge))) else $error("sampling while converting");
endmodule // arfmt_checker

bind arfmt_core arfmt_checker #(.RC_DIV(RC_DIV)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .analog_ctl(analog_ctl));

// ===== tb/tb_top.sv
// Testbench: register access, result layout and conversion timing
`timescale 1ns/100ps
module tb_top;
    import arfmt_pkg::*;
    localparam int RCD = 4; // Short RC period keeps the run brief
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    arfmt_result_t res;
    arfmt_analog_t actl;
    int n_fail = 0, checks_done = 0, cyc = 0, conv_cnt = 0, dis_cnt = 0, t_rise = 0, t_wr = 0;
    int tick_cnt = 0; // Bit ticks seen while converting
    int exp_q[$]; // Model: raw results waiting to be read back
    int per [8] = '{2, 8, 32, RCD, 4, 16, 64, RCD}; // Clocks per bit period by clock code
    int acqp [8] = '{0, 2, 4, 6, 8, 12, 16, 20}; // Bit periods by acquisition code
    logic conv_d = 1'b0;
    logic [15:0] seed = 16'h50FF;
    arfmt_core #(.RC_DIV(RCD)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .result_in(res), .analog_ctl(actl));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Write: both channels offered together, response held off two edges
    task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        repeat (2) @(posedge aclk);
        t_wr = cyc;
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    // Read: answer is held off two edges to see it stand
    task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        repeat (2) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Monitor: feeds the result once per conversion, times the phases, cuts hangs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        conv_d <= actl.convert;
        res.valid <= aresetn && actl.convert && !conv_d;
        if (actl.convert && !conv_d) t_rise <= cyc;
        if (actl.convert) conv_cnt <= conv_cnt + 1;
        if (actl.discharge) dis_cnt <= dis_cnt + 1;
        if (actl.bit_tick) tick_cnt <= tick_cnt + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        int c0, d0, k0, ts, ex, rv, hi, lo;
        logic just;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        res = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(OFS_CTRL_TWO, d, r);
        check(d, {24'h00_0000, CTRL_RESET}, "control reset");
        check({30'h0000_0000, r}, 32'h0000_0000, "read response okay");
        axw(OFS_CTRL_TWO, 32'hFFFF_FFFF, r);
        check({30'h0000_0000, r}, 32'h0000_0000, "write response okay");
        wstrb <= 4'h0;
        axw(OFS_CTRL_TWO, 32'h0000_0000, r);
        wstrb <= 4'hF;
        check({30'h0000_0000, r}, 32'h0000_0000, "zero strobe write response");
        axr(OFS_CTRL_TWO, d, r);
        check(d, {24'h00_0000, CTRL_WMASK}, "control bit 6 reads 0, zero strobe kept");
        axw(4'h2, 32'h0000_0000, r);
        check({30'h0000_0000, r}, 32'h0000_0002, "unmapped write response");
        axr(4'h2, d, r);
        check({30'h0000_0000, r}, 32'h0000_0002, "unmapped read response");
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            rv = seed[9:0];
            exp_q.push_back(rv);
            just = i[0];
            res.value <= seed[9:0];
            axw(OFS_CTRL_TWO, {24'h00_0000, just, 1'b0, 3'(7 - i), 3'(i)}, r);
            axw(OFS_START, 32'h0000_0002, r);
            axr(OFS_START, d, r);
            check(d, 32'h0000_0000, "done cleared");
            c0 = conv_cnt;
            d0 = dis_cnt;
            k0 = tick_cnt;
            axw(OFS_START, 32'h0000_0001, r);
            ts = t_wr;
            if (i == 6) axw(OFS_START, 32'h0000_0001, r);
            do axr(OFS_START, d, r); while (d[0] !== 1'b0);
            check(d, 32'h0000_0002, "done after conversion");
            check(32'(conv_cnt - c0), 32'(CONV_BITS * per[i]), "convert length");
            check(32'(dis_cnt - d0), 32'(per[i]), "discharge length");
            check(32'(tick_cnt - k0), 32'(CONV_BITS), "bit ticks");
            check(32'(actl.sample), 32'h0000_0001, "sampling in idle");
            ex = acqp[7 - i] * per[i] + ((i % 4 == 3) ? INSTR_CYCLE_CLKS : 0);
            check(32'(t_rise - ts >= ex - 1 && t_rise - ts <= ex + 2), 1, "acq delay");
            rv = exp_q.pop_front();
            hi = just ? (rv >> 8) : (rv >> 2);
            lo = just ? (rv & 255) : ((rv & 3) << 6);
            axr(OFS_RES_HIGH, d, r);
            check(d, 32'(hi), "result high");
            axr(OFS_RES_LOW, d, r);
            check(d, 32'(lo), "result low");
            $display("conversion test %0d done", i);
        end
        summarize();
    end
endmodule // tb_top
